/* src/scq_pkg.sv */
// Shared constants and types of the sequencer channel qualifier
package scq_pkg;

  // ****************************************
  // Clock and timer tick
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 10;    // 100 MHz system clock
  localparam int unsigned TICK_PERIOD_NS = 1000;  // Timers count in 1 us ticks
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_SETTLE    = 2;     // Cycles before disable levels are caught

  // ****************************************
  // Channels
  // ****************************************
  localparam int unsigned NUM_CH   = 4;
  localparam logic [2:0]  LAST_CH  = 3'h3;        // Highest channel index
  localparam logic [2:0]  DONE_IDX = 3'h4;        // Marker past the last channel

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0]  OFF_CTRL   = 4'h0;      // Write only: commands
  localparam logic [3:0]  OFF_STEP   = 4'h4;      // Step delay setting, us
  localparam logic [3:0]  OFF_REGTO  = 4'h8;      // Regulation timeout, us, 0 = off
  localparam logic [3:0]  OFF_STATUS = 4'hC;      // Status, fault clears on write one
  localparam logic [15:0] STEP_RST   = 16'h00FA;  // 250 us after reset
  localparam logic [15:0] REGTO_RST  = 16'h0000;  // Timeout off after reset

  // Field positions
  localparam int unsigned CTRL_UP_BIT   = 0;
  localparam int unsigned CTRL_DOWN_BIT = 1;
  localparam int unsigned ST_EN_LSB     = 0;
  localparam int unsigned ST_INREG_LSB  = 4;
  localparam int unsigned ST_DIS_LSB    = 8;
  localparam int unsigned ST_DONE_BIT   = 12;
  localparam int unsigned ST_PGOOD_BIT  = 13;
  localparam int unsigned ST_FAULT_BIT  = 14;
  localparam int unsigned ST_BUSY_BIT   = 15;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    SCQ_IDLE,
    SCQ_UP_DLY,
    SCQ_UP_WAIT,
    SCQ_UP_ON,
    SCQ_DN_DLY,
    SCQ_DN_WAIT,
    SCQ_DN_LAST
  } scq_state_t;

endpackage : scq_pkg

/* src/scq_qual_if.sv */
// Interface carrying qualified channel status to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface scq_qual_if;
  logic [3:0] in_reg;    // Hysteresis flag per channel
  logic [3:0] disabled;  // Caught skip mask, cumulative upward
  logic       ready;     // Skip mask has been caught

  modport qual (output in_reg, output disabled, output ready);
  modport seq  (input in_reg, input disabled, input ready);
endinterface : scq_qual_if
`default_nettype wire

/* src/scq_step_timer.sv */
// Microsecond down-counter with tick divider, used for delays and timeouts
`timescale 1ns/1ps
`default_nettype none
module scq_step_timer
  import scq_pkg::*;
#(
  parameter int unsigned WIDTH = 16
)(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             start_in,   // Load and run
  input  wire logic             clear_in,   // Abort without done
  input  wire logic [WIDTH-1:0] load_in,    // Length in ticks
  output logic                  done_out    // One-cycle expiry pulse
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [WIDTH-1:0] cnt;   // Ticks left
    logic [7:0]       div;   // Cycles within tick
    logic             run;   // Counting
    logic             done;  // Expiry pulse
  } scq_tmr_t;

  scq_tmr_t q;       // Registered state
  scq_tmr_t next_q;  // Next state

  assign done_out = q.done;

  // Next state: tick divider and countdown
  always_comb
  begin
    next_q      = q;
    next_q.done = 1'b0;
    if (clear_in)
    begin
      next_q.run = 1'b0;
    end
    else if (start_in)
    begin
      next_q.cnt = load_in;
      next_q.div = 8'h00;
      // Zero length expires at once
      next_q.run  = (load_in != '0);
      next_q.done = (load_in == '0);
    end
    else if (q.run)
    begin
      if (q.div == 8'(TICK_CYCLES - 1))
      begin
        next_q.div = 8'h00;
        if (q.cnt == WIDTH'(1))
        begin
          next_q.run  = 1'b0;
          next_q.done = 1'b1;
        end
        else
        begin
          next_q.cnt = q.cnt - WIDTH'(1);
        end
      end
      else
      begin
        next_q.div = q.div + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      q <= '0;
    else
      q <= next_q;
  end

endmodule // scq_step_timer
`default_nettype wire

/* src/scq_channel_qual.sv */
// Per-channel sense synchronisers, hysteresis flags and skip mask
`timescale 1ns/1ps
`default_nettype none
module scq_channel_qual
  import scq_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  sense_above_on_in,   // Above rising threshold
  input  wire logic [3:0]  sense_above_off_in,  // Above rail off level
  input  wire logic [3:0]  sense_disable_in,    // Above turn-off level
  scq_qual_if.qual         qual
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0] on_s1, on_s2;    // Rising comparator sync
    logic [3:0] off_s1, off_s2;  // Off comparator sync
    logic [3:0] dis_s1, dis_s2;  // Disable level sync
    logic [3:0] flag;            // In-regulation flags
    logic [3:0] dis;             // Caught skip mask
    logic [1:0] settle;          // Settle counter
    logic       ready;           // Mask caught
  } scq_qual_t;

  scq_qual_t q;       // Registered state
  scq_qual_t next_q;  // Next state

  assign qual.in_reg   = q.flag;
  assign qual.disabled = q.dis;
  assign qual.ready    = q.ready;

  // Next state
  always_comb
  begin
    next_q        = q;
    next_q.on_s1  = sense_above_on_in;
    next_q.on_s2  = q.on_s1;
    next_q.off_s1 = sense_above_off_in;
    next_q.off_s2 = q.off_s1;
    next_q.dis_s1 = sense_disable_in;
    next_q.dis_s2 = q.dis_s1;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // Set above rising threshold, clear only below off level
      if (q.on_s2[i])
        next_q.flag[i] = 1'b1;
      else if (!q.off_s2[i])
        next_q.flag[i] = 1'b0;
    end
    // Catch skip mask once after reset, levels are static from then on
    if (!q.ready)
    begin
      if (q.settle == 2'(SYNC_SETTLE))
      begin
        next_q.ready  = 1'b1;
        next_q.dis[0] = 1'b0;
        for (int i = 1; i < NUM_CH; i++)
          next_q.dis[i] = next_q.dis[i-1] | q.dis_s2[i];
      end
      else
      begin
        next_q.settle = q.settle + 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      q <= '0;
    else
      q <= next_q;
  end

endmodule // scq_channel_qual
`default_nettype wire

/* src/scq_sequencer.sv */
// Four-channel sequencer top with Avalon-MM register slave
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Four channels, each sense flag and enable
// - Up walks 1 to 4, down 4 to 1
// - Flag set above rising threshold
// - Flag clears only below off level
// - Sense above turn-off level disables channel
// - Channel 1 can never be skipped
// - A skipped channel skips all above it
// - No step delay for skipped channels
// - Up: next enable after step delay
// - Down: next lower enable off after delay
module scq_sequencer
  import scq_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [3:0]  channel_sense_input_in,     // Rising threshold comparators
  input  wire logic [3:0]  channel_sense_off_in,       // Off level comparators
  input  wire logic [3:0]  channel_sense_disable_in,   // Turn-off level comparators
  output logic [3:0]       channel_enable_output_out,  // Rail enables
  output logic             seq_done_out,
  output logic             power_good_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    scq_state_t  st;        // Sequencer state
    logic [2:0]  ch;        // Current channel
    logic [3:0]  en;        // Enable outputs
    logic        done;      // Sequence done
    logic        pgood;     // Power good
    logic        fault;     // Regulation timeout, sticky
    logic [15:0] step;      // Step delay setting
    logic [15:0] regto;     // Regulation timeout setting
    logic        wreq;      // Waitrequest
    logic [31:0] rdata;     // Read data
    logic        s_start;   // Step timer start
    logic        r_start;   // Regulation timer start
    logic        r_clr;     // Regulation timer abort
  } scq_top_t;

  scq_top_t q;       // Registered state
  scq_top_t next_q;  // Next state

  logic step_done;   // Step delay expired
  logic reg_done;    // Regulation timeout expired

  scq_qual_if qif ();  // Qualified channel status

  // ****************************************
  // Submodules
  // ****************************************
  // Sense qualification and skip mask
  scq_channel_qual u_qual (
    .sys_clk_in         (sys_clk_in),
    .rst_b_in           (rst_b_in),
    .sense_above_on_in  (channel_sense_input_in),
    .sense_above_off_in (channel_sense_off_in),
    .sense_disable_in   (channel_sense_disable_in),
    .qual               (qif)
  );

  // Step delay timer
  scq_step_timer #(.WIDTH(16)) u_step (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (q.s_start),
    .clear_in   (1'b0),
    .load_in    (q.step),
    .done_out   (step_done)
  );

  // Regulation timeout timer
  scq_step_timer #(.WIDTH(16)) u_regto (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (q.r_start),
    .clear_in   (q.r_clr),
    .load_in    (q.regto),
    .done_out   (reg_done)
  );

  assign avs_readdata_out          = q.rdata;
  assign avs_waitrequest_out       = q.wreq;
  assign channel_enable_output_out = q.en;
  assign seq_done_out              = q.done;
  assign power_good_out            = q.pgood;

  // ****************************************
  // Helpers
  // ****************************************
  // Channel index is skipped
  function automatic logic skip(input logic [2:0] c, input logic [3:0] dis);
    skip = (c <= LAST_CH) && dis[c[1:0]];
  endfunction

  // Rail in regulation, skipped counts as met
  function automatic logic met_up(input logic [2:0] c, input logic [3:0] f,
                                  input logic [3:0] dis);
    met_up = f[c[1:0]] || skip(c, dis);
  endfunction

  // Rail below off level, skipped counts as met
  function automatic logic met_down(input logic [2:0] c, input logic [3:0] f,
                                    input logic [3:0] dis);
    met_down = !f[c[1:0]] || skip(c, dis);
  endfunction

  // Byte-lane merge for the low half word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // Next state: bus slave and sequencer
  // ****************************************
  always_comb
  begin
    logic        commit;   // Write takes effect now
    logic        cmd_up;   // Sequence up command
    logic        cmd_dn;   // Sequence down command
    logic [31:0] status;   // Status word
    commit         = 1'b0;
    cmd_up         = 1'b0;
    cmd_dn         = 1'b0;
    status         = '0;
    next_q         = q;
    next_q.s_start = 1'b0;
    next_q.r_start = 1'b0;
    next_q.r_clr   = 1'b0;

    // Status word
    status[ST_EN_LSB +: 4]    = q.en;
    status[ST_INREG_LSB +: 4] = qif.in_reg;
    status[ST_DIS_LSB +: 4]   = qif.disabled;
    status[ST_DONE_BIT]       = q.done;
    status[ST_PGOOD_BIT]      = q.pgood;
    status[ST_FAULT_BIT]      = q.fault;
    status[ST_BUSY_BIT]       = (q.st != SCQ_IDLE) && (q.st != SCQ_UP_ON);

    // One wait state: answer on the cycle after the request is seen
    if ((avs_read_in || avs_write_in) && q.wreq)
    begin
      next_q.wreq = 1'b0;
      if (avs_read_in)
      begin
        case (avs_address_in)
          OFF_STEP:   next_q.rdata = {16'h0000, q.step};
          OFF_REGTO:  next_q.rdata = {16'h0000, q.regto};
          OFF_STATUS: next_q.rdata = status;
          default:    next_q.rdata = 32'h0000_0000;  // Control and unmapped
        endcase
      end
    end
    else
    begin
      next_q.wreq = 1'b1;
      commit      = avs_write_in && !q.wreq;
    end

    // Register writes
    if (commit)
    begin
      case (avs_address_in)
        OFF_CTRL:
        begin
          cmd_up = avs_byteenable_in[0] && avs_writedata_in[CTRL_UP_BIT];
          cmd_dn = avs_byteenable_in[0] && avs_writedata_in[CTRL_DOWN_BIT];
        end
        OFF_STEP:  next_q.step  = merge(q.step, avs_writedata_in, avs_byteenable_in);
        OFF_REGTO: next_q.regto = merge(q.regto, avs_writedata_in, avs_byteenable_in);
        OFF_STATUS:
        begin
          if (avs_byteenable_in[1] && avs_writedata_in[ST_FAULT_BIT])
            next_q.fault = 1'b0;
        end
        default:
        begin
          next_q.fault = next_q.fault;  // Unmapped writes ignored
        end
      endcase
    end

    // Sequencer
    if (cmd_dn && (q.st == SCQ_UP_DLY || q.st == SCQ_UP_WAIT || q.st == SCQ_UP_ON))
    begin
      // Down from channel 4, power good drops at once
      next_q.pgood   = 1'b0;
      next_q.r_clr   = 1'b1;
      next_q.ch      = LAST_CH;
      next_q.st      = SCQ_DN_DLY;
      next_q.s_start = !skip(LAST_CH, qif.disabled);
    end
    else
    begin
      case (q.st)
        SCQ_IDLE:
        begin
          if (cmd_up && qif.ready)
          begin
            next_q.ch      = 3'h0;
            next_q.st      = SCQ_UP_DLY;
            next_q.s_start = 1'b1;
          end
        end
        SCQ_UP_DLY:
        begin
          if (step_done || skip(q.ch, qif.disabled))
          begin
            if (q.ch == DONE_IDX)
            begin
              next_q.done  = 1'b1;
              next_q.pgood = 1'b1;
              next_q.st    = SCQ_UP_ON;
            end
            else
            begin
              next_q.en[q.ch[1:0]] = 1'b1;
              next_q.st            = SCQ_UP_WAIT;
              next_q.r_start = (q.regto != 16'h0000) && !skip(q.ch, qif.disabled);
            end
          end
        end
        SCQ_UP_WAIT:
        begin
          if (met_up(q.ch, qif.in_reg, qif.disabled))
          begin
            // Ascending order, next channel after step delay
            next_q.r_clr   = 1'b1;
            next_q.ch      = q.ch + 3'h1;
            next_q.st      = SCQ_UP_DLY;
            next_q.s_start = !skip(q.ch + 3'h1, qif.disabled);
          end
          else if (reg_done)
          begin
            // Timeout: drop this rail, reverse down from the one below
            next_q.fault         = 1'b1;
            next_q.en[q.ch[1:0]] = 1'b0;
            if (q.ch == 3'h0)
            begin
              next_q.st      = SCQ_DN_LAST;
              next_q.s_start = 1'b1;
            end
            else
            begin
              next_q.ch      = q.ch - 3'h1;
              next_q.st      = SCQ_DN_DLY;
              next_q.s_start = 1'b1;
            end
          end
        end
        SCQ_UP_ON:
        begin
          if (!qif.in_reg[0])
            next_q.pgood = 1'b0;
        end
        SCQ_DN_DLY:
        begin
          if (step_done || skip(q.ch, qif.disabled))
          begin
            next_q.en[q.ch[1:0]] = 1'b0;
            next_q.st            = SCQ_DN_WAIT;
          end
        end
        SCQ_DN_WAIT:
        begin
          if (met_down(q.ch, qif.in_reg, qif.disabled))
          begin
            if (q.ch == 3'h0)
            begin
              next_q.st      = SCQ_DN_LAST;
              next_q.s_start = 1'b1;
            end
            else
            begin
              // Descending order, lower channel after step delay
              next_q.ch      = q.ch - 3'h1;
              next_q.st      = SCQ_DN_DLY;
              next_q.s_start = !skip(q.ch - 3'h1, qif.disabled);
            end
          end
        end
        SCQ_DN_LAST:
        begin
          if (step_done)
          begin
            next_q.done = 1'b0;
            next_q.st   = SCQ_IDLE;
          end
        end
        default:
        begin
          next_q.st = SCQ_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q       <= '0;
      q.st    <= SCQ_IDLE;
      q.step  <= STEP_RST;
      q.regto <= REGTO_RST;
      q.wreq  <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

endmodule // scq_sequencer
`default_nettype wire

/* tb/scq_sequencer_assertions.sv */
// Concurrent port checks for the sequencer top
`timescale 1ns/1ps
`default_nettype none
module scq_sequencer_assertions
  import scq_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [3:0] channel_sense_off_in,
  input wire logic [3:0] channel_sense_disable_in,
  input wire logic [3:0] channel_enable_output_out,
  input wire logic       seq_done_out,
  input wire logic       power_good_out
);
  // ****************************************
  // Port properties
  // ****************************************
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire [3:0] en = channel_enable_output_out;  // Short alias
  wire [3:0] dis = channel_sense_disable_in;  // Short alias

  reset_quiet_a: assert property ($rose(rst_b_in) |->
    en == 4'h0 && !seq_done_out && !power_good_out)
    else $error("outputs not quiet after reset");
  enable_order_a: assert property (en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("enables out of channel order");
  up_after_prev_a: assert property ($rose(en[1]) |-> $past(channel_sense_off_in[0]))
    else $error("channel two enabled before channel one regulated");
  down_after_off_a: assert property ($fell(en[0]) |->
    !$past(channel_sense_off_in[1]) || dis[1])
    else $error("channel one dropped while channel two above off level");
  skip_follow_a: assert property ($rose(en[1]) && dis[1] |-> ##[1:8] en[2])
    else $error("skipped channel delayed the next one");
  skip_cascade_a: assert property ($rose(en[2]) && dis[2] && !dis[3] |-> ##[1:8] en[3])
    else $error("skip did not cascade upward");
  skip_down_a: assert property ($fell(en[3]) && dis[2] |-> ##[1:8] !en[2])
    else $error("skipped channel waited on the way down");
  done_all_a: assert property ($rose(seq_done_out) |-> en == 4'hF && power_good_out)
    else $error("done without every enable high");
  down_end_a: assert property ($fell(seq_done_out) |-> en == 4'h0 && !power_good_out)
    else $error("done dropped before every enable low");
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");

  up_done_c: cover property ($rose(seq_done_out));
  down_done_c: cover property ($fell(seq_done_out));
  skip_top_c: cover property ($rose(en[3]) && dis[3]);
endmodule // scq_sequencer_assertions

bind scq_sequencer scq_sequencer_assertions scq_sequencer_assertions_i (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .avs_waitrequest_out(avs_waitrequest_out),
  .channel_sense_off_in(channel_sense_off_in),
  .channel_sense_disable_in(channel_sense_disable_in),
  .channel_enable_output_out(channel_enable_output_out),
  .seq_done_out(seq_done_out), .power_good_out(power_good_out));
`default_nettype wire

/* tb/scq_rail_model.sv */
// Behavioural model of four enabled and monitored regulator rails
`timescale 1ns/1ps
`default_nettype none
module scq_rail_model
  import scq_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic [3:0] enable_in,          // Rail enables
  input  wire logic [3:0] skip_in,            // Inputs tied high, above every level; for channel one only the turn-off input
  input  wire logic [3:0] stuck_in,           // Rails that never come up
  input  wire logic [3:0] droop_in,           // Rails sagging inside hysteresis
  input  wire logic [7:0] pace_in,            // Cycles per ramp step, minus one
  output logic      [3:0] above_on_out,
  output logic      [3:0] above_off_out,
  output logic      [3:0] above_turnoff_out
);
  // ****************************************
  // Rail ramps
  // ****************************************
  logic [3:0] lvl [4] = '{default: 4'h0};     // Rail level per channel
  logic [7:0] pace_cnt = 8'h00;               // Ramp pace divider

  // Ramp up while enabled and not stuck, discharge otherwise
  always_ff @(posedge sys_clk_in)
  begin
    pace_cnt <= (pace_cnt >= pace_in) ? 8'h00 : pace_cnt + 8'h01;
    for (int i = 0; i < 4; i++)
    begin
      if (pace_cnt == 8'h00 && enable_in[i] && !stuck_in[i] && lvl[i] != 4'hF)
        lvl[i] <= lvl[i] + 4'h1;
      else if (pace_cnt == 8'h00 && !(enable_in[i] && !stuck_in[i]) && lvl[i] != 4'h0)
        lvl[i] <= lvl[i] - 4'h1;
    end
  end

  // Comparators; tied inputs sit above every level and never move.
  // Channel one cannot be skipped, so its rail stays live and only
  // its turn-off comparator follows the tie
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      above_on_out[i]      = (skip_in[i] && i != 0) | (lvl[i] >= 4'hA && !droop_in[i]);
      above_off_out[i]     = (skip_in[i] && i != 0) | (lvl[i] >= 4'h4);
      above_turnoff_out[i] = skip_in[i];
    end
  end
endmodule // scq_rail_model
`default_nettype wire

/* tb/sequencer_channel_qualifier_test.sv */
// Self-checking bench for the sequencer with rail partner model
`timescale 1ns/1ps
`default_nettype none
module sequencer_channel_qualifier_test;
  import scq_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        sys_clk_in;
  logic        rst_b_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [3:0]  sense_on, sense_off, sense_dis, enables;
  logic        seq_done_out, power_good_out;
  logic [3:0]  skip = 4'h0, stuck = 4'h0, droop = 4'h0;
  logic [7:0]  pace = 8'h00;
  logic [31:0] q, r, seed;
  logic [3:0]  d;
  int          n_mismatch = 0, checks = 0, cycles = 0;

  scq_sequencer scq_sequencer_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .channel_sense_input_in(sense_on), .channel_sense_off_in(sense_off),
    .channel_sense_disable_in(sense_dis), .channel_enable_output_out(enables),
    .seq_done_out(seq_done_out), .power_good_out(power_good_out));
  scq_rail_model scq_rail_model_i (.sys_clk_in(sys_clk_in), .enable_in(enables),
    .skip_in(skip), .stuck_in(stuck), .droop_in(droop), .pace_in(pace),
    .above_on_out(sense_on), .above_off_out(sense_off), .above_turnoff_out(sense_dis));

  // ****************************************
  // Clock, timeout and tasks
  // ****************************************
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Cut a hung run short
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= wd;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    check("bus answer", 32'h1, {31'h0, n < 100});
  endtask

  task automatic wait_done(input logic lvl);
    int n;
    n = 0;
    while (seq_done_out !== lvl && n < 20000)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    check("seq_done", {31'h0, lvl}, {31'h0, seq_done_out});
  endtask

  // Skip levels change only while the device is held in reset
  task automatic do_reset(input logic [3:0] dis);
    rst_b_in <= 1'b0;
    skip <= dis;
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
  endtask

  function automatic logic [3:0] exp_mask(input logic [3:0] dis);
    exp_mask = 4'h0;
    for (int i = 1; i < 4; i++)
      exp_mask[i] = exp_mask[i - 1] | dis[i];
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 32'h2767;
    do_reset(4'h0);
    bus(1'b0, OFF_STEP, 32'h0);
    check("step reset", {16'h0, STEP_RST}, q);
    bus(1'b0, OFF_REGTO, 32'h0);
    check("timeout reset", {16'h0, REGTO_RST}, q);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped read", 32'h0, q);
    // Skip patterns: fixed corners then random, channel one bit included
    for (int k = 0; k < 8; k++)
    begin
      r = $random(seed);
      d = (k == 1) ? 4'h8 : (k == 2) ? 4'h4 : (k == 3) ? 4'h2 : (k == 0) ? 4'h0 : r[7:4];
      do_reset(d);
      pace <= {6'h0, r[1:0]};
      bus(1'b1, OFF_STEP, {30'h0, r[3:2]});
      bus(1'b1, OFF_REGTO, 32'h64);
      bus(1'b1, OFF_CTRL, 32'h1);
      wait_done(1'b1);
      check("enables up", 32'hF, {28'h0, enables});
      bus(1'b0, OFF_STATUS, 32'h0);
      check("skip mask", {28'h0, exp_mask(d)}, {28'h0, q[11:8]});
      check("done pgood", 32'h3, {30'h0, q[13:12]});
      if (k == 0)
      begin
        droop <= 4'h1;
        repeat (40) @(posedge sys_clk_in);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("flag held", 32'h1, {31'h0, q[4]});
        check("pgood held", 32'h1, {31'h0, power_good_out});
        droop <= 4'h0;
      end
      bus(1'b1, OFF_CTRL, 32'h2);
      wait_done(1'b0);
      check("enables down", 32'h0, {28'h0, enables});
      check("pgood down", 32'h0, {31'h0, power_good_out});
    end
    // Channel two never regulates: timeout, then orderly fall
    do_reset(4'h0);
    stuck <= 4'h2;
    bus(1'b1, OFF_STEP, 32'h1);
    bus(1'b1, OFF_REGTO, 32'h2);
    bus(1'b1, OFF_CTRL, 32'h1);
    for (int n = 0; n < 400; n++)
    begin
      bus(1'b0, OFF_STATUS, 32'h0);
      if (q[14] === 1'b1 && q[3:0] === 4'h0)
        break;
    end
    check("fault fall", 32'h4000, {16'h0, q[15:0]} & 32'h700F);
    // Sticky fault clears on a write of one
    bus(1'b1, OFF_STATUS, 32'h4000);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("fault clear", 32'h0, {31'h0, q[14]});
    tally_and_finish();
  end
endmodule // sequencer_channel_qualifier_test
`default_nettype wire
